// [hw/ccu_compare_unit.sv]
// Two-instance output-compare unit with APB registers and a level interrupt.
// Operation
// - Compare value continuously against selected timer.
// - Match drives pin high, low, toggle, none.
// - Flag sets in same cycle as pin.
// - Zero control write clears unit two latch.
// - Mode 1010 raises event only.
// - Interrupt needs enable bit set.
// - Mode 1011 emits special event trigger.
// - Trigger clears the assigned timer count.
// - Only unit two trigger starts conversion.
// - Unimplemented bits read as zero.
// - Small package drops enhanced config bits.
// - PWM duty resolution at most 10 bits.
// - Mode 1001 sets high, match forces low.
// - Timer selection bits choose each time base.
module ccu_compare_unit
  import ccu_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_one_count,
  input wire logic [15:0] timer_three_count,
  input wire logic adc_enabled,
  output logic timer_one_clear,
  output logic timer_three_clear,
  output logic adc_start,
  output logic [1:0] compare_pin_out,
  output logic [1:0] compare_pin_oe,
  output logic irq
);
  logic [15:0] value_q [2];
  logic [7:0] ctl_q [2];
  logic [1:0] tsel_q;
  logic [1:0] flag_q;
  logic [1:0] mask_q;
  logic [1:0] pin_dir_q;
  logic [1:0] latch_q;
  logic [1:0] pwm_q;
  logic [9:0] pwm_cnt_q;
  logic [1:0] match;
  logic [1:0] trig;
  logic [1:0] active;
  logic [15:0] base [2];
  logic [15:0] prev_q [2];
  logic [1:0] seen_q;
  logic wr_en;
  logic rd_en;

  function automatic logic is_compare(input logic [7:0] ctl);
    return ctl[MODE_MSB] && ctl[MODE_MSB-1:MODE_LSB+2] == 1'b0;
  endfunction

  function automatic ccu_action_t action_of(input logic [3:0] mode);
    case (mode)
      MODE_SET_HI: return CCU_ACT_HIGH;
      MODE_SET_LO: return CCU_ACT_LOW;
      MODE_TOGGLE: return CCU_ACT_TOGGLE;
      default: return CCU_ACT_NONE;
    endcase
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  genvar u;
  generate
    for (u = 0; u < 2; u++) begin : g_unit
      // Timer pairing per unit: unit one uses timer three only when the high select bit is set.
      always_comb begin
        if (u == 0) begin
          active[u] = tsel_q[TSEL_HI_BIT];
        end else begin
          active[u] = tsel_q[TSEL_HI_BIT] | tsel_q[TSEL_LO_BIT];
        end
        base[u] = active[u] ? timer_three_count : timer_one_count;
      end
      // Equality is caught once per timer value; a stalled timer gives one event only.
      assign match[u] = (is_compare(ctl_q[u]) || ctl_q[u][MODE_LSB+1 +: 3] == 3'b001)
                        && base[u] == value_q[u]
                        && !(seen_q[u] && prev_q[u] == base[u]);
      assign trig[u] = match[u] && ctl_q[u][MODE_MSB:MODE_LSB] == MODE_SPECIAL;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          prev_q[u] <= VALUE_RESET;
          seen_q[u] <= 1'b0;
        end else begin
          prev_q[u] <= base[u];
          seen_q[u] <= base[u] == value_q[u];
        end
      end
      // Compare output latch; separate from any port data latch.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          latch_q[u] <= 1'b0;
        end else if (wr_en && paddr == (u == 0 ? ADDR_U1_CTL : ADDR_U2_CTL)) begin
          if (pwdata[MODE_MSB:MODE_LSB] == MODE_SET_LO) begin
            latch_q[u] <= 1'b1;
          end else if (pwdata[MODE_MSB:MODE_LSB] == MODE_SET_HI) begin
            latch_q[u] <= 1'b0;
          end else if (pwdata[CFG_MSB:MODE_LSB] == CTL_RESET) begin
            latch_q[u] <= 1'b0;
          end
        end else if (match[u]) begin
          case (action_of(ctl_q[u][MODE_MSB:MODE_LSB]))
            CCU_ACT_HIGH: latch_q[u] <= 1'b1;
            CCU_ACT_LOW: latch_q[u] <= 1'b0;
            CCU_ACT_TOGGLE: latch_q[u] <= ~latch_q[u];
            default: latch_q[u] <= latch_q[u];
          endcase
        end
      end
      // PWM compares the 8-bit value plus two duty bits to a free 10-bit count.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pwm_q[u] <= 1'b0;
        end else begin
          pwm_q[u] <= pwm_cnt_q < {value_q[u][7:0], ctl_q[u][DUTY_MSB:DUTY_LSB]};
        end
      end
      // The pin is driven only when software has set it to output.
      assign compare_pin_out[u] = ctl_q[u][MODE_MSB-:2] == MODE_PWM_TOP ? pwm_q[u] : latch_q[u];
      assign compare_pin_oe[u] = pin_dir_q[u];
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_cnt_q <= '0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 10'h001;
    end
  end

  // Compare values: each byte is its own register, so a 16-bit update takes two writes.
  // Software should write both bytes while the unit is off to avoid a stray match.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      value_q[0] <= VALUE_RESET;
      value_q[1] <= VALUE_RESET;
    end else if (wr_en) begin
      case (paddr)
        ADDR_U1_LO: value_q[0][7:0] <= pwdata[7:0];
        ADDR_U1_HI: value_q[0][15:8] <= pwdata[7:0];
        ADDR_U2_LO: value_q[1][7:0] <= pwdata[7:0];
        ADDR_U2_HI: value_q[1][15:8] <= pwdata[7:0];
        default: value_q[0] <= value_q[0];
      endcase
    end
  end

  // Control registers; absent bits are never stored, so they cannot read back as one.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_q[0] <= CTL_RESET;
      ctl_q[1] <= CTL_RESET;
    end else if (wr_en) begin
      case (paddr)
        ADDR_U1_CTL: ctl_q[0] <= SMALL_PACKAGE ? {2'b00, pwdata[DUTY_MSB:0]} : pwdata[7:0];
        ADDR_U2_CTL: ctl_q[1] <= {2'b00, pwdata[DUTY_MSB:0]};
        default: ctl_q[0] <= ctl_q[0];
      endcase
    end
  end

  // Timer selection bits.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tsel_q <= '0;
    end else if (wr_en && paddr == ADDR_TSEL) begin
      tsel_q <= pwdata[1:0];
    end
  end

  // Interrupt mask.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (wr_en && paddr == ADDR_MASK) begin
      mask_q <= pwdata[NUM_EV-1:0];
    end
  end

  // Pin direction; both pins come out of reset as inputs so nothing is driven by surprise.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_dir_q <= '0;
    end else if (wr_en && paddr == ADDR_PINS) begin
      pin_dir_q <= pwdata[1:0];
    end
  end

  // Event flags: hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~((wr_en && paddr == ADDR_STATUS) ? pwdata[NUM_EV-1:0] : 2'b00))
                | match;
    end
  end

  assign irq = |(flag_q & mask_q);
  assign timer_one_clear = (trig[0] && !active[0]) || (trig[1] && !active[1]);
  assign timer_three_clear = (trig[0] && active[0]) || (trig[1] && active[1]);
  assign adc_start = trig[1] && adc_enabled;

  // Read data is driven from the setup cycle on, as penable is not needed; unmapped addresses read zero.
  always_comb begin
    case (paddr)
      ADDR_U1_LO: prdata = {24'h00_0000, value_q[0][7:0]};
      ADDR_U1_HI: prdata = {24'h00_0000, value_q[0][15:8]};
      ADDR_U1_CTL: prdata = {24'h00_0000, ctl_q[0]};
      ADDR_U2_LO: prdata = {24'h00_0000, value_q[1][7:0]};
      ADDR_U2_HI: prdata = {24'h00_0000, value_q[1][15:8]};
      ADDR_U2_CTL: prdata = {24'h00_0000, ctl_q[1]};
      ADDR_TSEL: prdata = {30'h0000_0000, tsel_q};
      ADDR_STATUS: prdata = {30'h0000_0000, flag_q};
      ADDR_MASK: prdata = {30'h0000_0000, mask_q};
      ADDR_PINS: prdata = {30'h0000_0000, pin_dir_q};
      default: begin
        prdata = RDATA_ZERO;
      end
    endcase
    if (!rd_en) begin
      prdata = RDATA_ZERO;
    end
  end

  match_flag_a: assert property (@(posedge clock) disable iff (rst)
    match[0] |=> flag_q[0]) else $error("Unit one flag not set after match.");
  flag_sticky_a: assert property (@(posedge clock) disable iff (rst)
    flag_q[1] && !(wr_en && paddr == ADDR_STATUS) |=> flag_q[1])
    else $error("Unit two flag cleared by hardware.");
  irq_gate_a: assert property (@(posedge clock) disable iff (rst)
    irq == |(flag_q & mask_q)) else $error("Interrupt not gated by mask.");
  adc_unit2_a: assert property (@(posedge clock) disable iff (rst)
    adc_start |-> ctl_q[1][MODE_MSB:MODE_LSB] == MODE_SPECIAL && base[1] == value_q[1]
    && adc_enabled) else $error("Conversion started wrongly.");

  u1_no_adc_a: assert property (@(posedge clock) disable iff (rst)
    trig[0] && !trig[1] |-> !adc_start) else $error("Unit one started a conversion.");

  entry_high_a: assert property (@(posedge clock) disable iff (rst)
    wr_en && paddr == ADDR_U1_CTL && pwdata[MODE_MSB:MODE_LSB] == MODE_SET_LO |=> latch_q[0])
    else $error("Entry did not set the output high.");

  set_low_a: assert property (@(posedge clock) disable iff (rst)
    match[0] && ctl_q[0][MODE_MSB:MODE_LSB] == MODE_SET_LO && !wr_en |=> !latch_q[0])
    else $error("Match did not force the output low.");

  set_high_a: assert property (@(posedge clock) disable iff (rst)
    match[1] && ctl_q[1][MODE_MSB:MODE_LSB] == MODE_SET_HI && !wr_en |=> latch_q[1])
    else $error("Match did not drive the output high.");

  ctl_zero_latch_a: assert property (@(posedge clock) disable iff (rst)
    wr_en && paddr == ADDR_U2_CTL && pwdata[CFG_MSB:MODE_LSB] == CTL_RESET |=> !latch_q[1])
    else $error("Zero control write left the latch high.");

  compare_hit_a: assert property (@(posedge clock) disable iff (rst)
    is_compare(ctl_q[0]) && base[0] == value_q[0] && !seen_q[0] |-> match[0])
    else $error("Equal value missed by the comparator.");

  u2_flag_a: assert property (@(posedge clock) disable iff (rst)
    match[1] |=> flag_q[1]) else $error("Unit two flag not set after match.");

  clear_select_a: assert property (@(posedge clock) disable iff (rst)
    trig[0] |-> (active[0] ? timer_three_clear : timer_one_clear))
    else $error("Unit one trigger cleared the wrong timer.");

  read_top_zero_a: assert property (@(posedge clock) disable iff (rst)
    prdata[31:8] == 24'h00_0000) else $error("Unused read bits set.");

  small_pkg_a: assert property (@(posedge clock) disable iff (rst)
    !SMALL_PACKAGE || ctl_q[0][CFG_MSB:CFG_LSB] == 2'b00)
    else $error("Absent configuration bits stored.");

  pwm_res_a: assert property (@(posedge clock) disable iff (rst)
    ctl_q[0][MODE_MSB-:2] == MODE_PWM_TOP && pwm_cnt_q == 10'h000
    && {value_q[0][7:0], ctl_q[0][DUTY_MSB:DUTY_LSB]} != 10'h000 |=> pwm_q[0])
    else $error("Modulated output not high at period start.");
  swirq_pin_a: assert property (@(posedge clock) disable iff (rst)
    match[0] && ctl_q[0][3:0] == MODE_SWIRQ && !wr_en |=> $stable(latch_q[0]))
    else $error("Pin moved in software-event mode.");
  toggle_pin_a: assert property (@(posedge clock) disable iff (rst)
    match[0] && ctl_q[0][3:0] == MODE_TOGGLE && !wr_en |=> latch_q[0] != $past(latch_q[0]))
    else $error("Toggle did not toggle.");
  single_match_a: assert property (@(posedge clock) disable iff (rst)
    match[0] && $stable(timer_one_count) && $stable(timer_three_count) && $stable(value_q[0])
    |=> !match[0]) else $error("Repeated match on same value.");
  trig_clear_a: assert property (@(posedge clock) disable iff (rst)
    trig[1] |-> (active[1] ? timer_three_clear : timer_one_clear))
    else $error("Trigger did not clear timer.");
  u2_top_zero_a: assert property (@(posedge clock) disable iff (rst)
    ctl_q[1][CFG_MSB:CFG_LSB] == 2'b00) else $error("Unit two top bits set.");
  match_cov: cover property (@(posedge clock) disable iff (rst) match[0]);
  trig_cov: cover property (@(posedge clock) disable iff (rst) adc_start);
  irq_cov: cover property (@(posedge clock) disable iff (rst) $rose(irq));
  toggle_cov: cover property (@(posedge clock) disable iff (rst)
    match[0] && ctl_q[0][MODE_MSB:MODE_LSB] == MODE_TOGGLE);
  clear3_cov: cover property (@(posedge clock) disable iff (rst) timer_three_clear);
endmodule

// [hw/ccu_pkg.sv]
// Constants and types shared by the compare unit.
package ccu_pkg;
  // Register byte addresses on the APB slave.
  localparam logic [7:0] ADDR_U1_LO = 8'h00;
  localparam logic [7:0] ADDR_U1_HI = 8'h04;
  localparam logic [7:0] ADDR_U1_CTL = 8'h08;
  localparam logic [7:0] ADDR_U2_LO = 8'h0C;
  localparam logic [7:0] ADDR_U2_HI = 8'h10;
  localparam logic [7:0] ADDR_U2_CTL = 8'h14;
  localparam logic [7:0] ADDR_TSEL = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam logic [7:0] ADDR_PINS = 8'h24;
  // Control register fields.
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int DUTY_LSB = 4;
  localparam int DUTY_MSB = 5;
  localparam int CFG_LSB = 6;
  localparam int CFG_MSB = 7;
  // Timer selection register bits.
  localparam int TSEL_LO_BIT = 0;
  localparam int TSEL_HI_BIT = 1;
  // Status and mask bits.
  localparam int EV_U1 = 0;
  localparam int EV_U2 = 1;
  localparam int NUM_EV = 2;
  // Mode select encodings.
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET_HI = 4'h8;
  localparam logic [3:0] MODE_SET_LO = 4'h9;
  localparam logic [3:0] MODE_SWIRQ = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam int PWM_BITS = 10;
  typedef enum logic [1:0] {CCU_ACT_NONE, CCU_ACT_HIGH, CCU_ACT_LOW, CCU_ACT_TOGGLE} ccu_action_t;
endpackage

// [verification/ccu_far_side.sv]
// Model of the shared timers and the converter that face the compare unit.
module ccu_far_side #(
  parameter logic [15:0] WRAP_MASK = 16'hFFFF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hold,
  input wire logic adc_on,
  input wire logic timer_one_clear,
  input wire logic timer_three_clear,
  input wire logic adc_start,
  output logic [15:0] timer_one_count,
  output logic [15:0] timer_three_count,
  output logic adc_enabled,
  output int n_clr1,
  output int n_clr3,
  output int n_conv
);
  timeunit 1ns;
  timeprecision 1ns;
  // Timers step on the unit's own clock; an unsynchronised count would break compares.
  // The wrap mask shortens the period so that matches come often in simulation.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_one_count <= 16'h0000;
      timer_three_count <= 16'h0000;
    end else begin
      timer_one_count <= timer_one_clear ? 16'h0000 :
        hold ? timer_one_count : (timer_one_count + 16'h0001) & WRAP_MASK;
      timer_three_count <= timer_three_clear ? 16'h0000 :
        hold ? timer_three_count : (timer_three_count + 16'h0001) & WRAP_MASK;
    end
  end
  // The converter is on only when the bench turns it on.
  assign adc_enabled = adc_on;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      n_clr1 <= 0;
      n_clr3 <= 0;
      n_conv <= 0;
    end else begin
      n_clr1 <= n_clr1 + int'(timer_one_clear);
      n_clr3 <= n_clr3 + int'(timer_three_clear);
      // A start that arrives while the converter is off is dropped.
      n_conv <= n_conv + int'(adc_start && adc_enabled);
    end
  end
endmodule

// [verification/tb.sv]
// Self-checking bench for the compare unit with its timer and converter model.
module tb
  import ccu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} ccu_row_t;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic hold = 1'b0, adc_on = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, t1c, t3c, adc_start, adc_enabled, irq;
  logic [15:0] t1, t3;
  logic [1:0] pin_out, pin_oe;
  int num_errors = 0, compares = 0, n_clr1, n_clr3, n_conv, c1, c3, cv;
  logic [3:0] modes [4] = '{MODE_SET_LO, MODE_SET_HI, MODE_TOGGLE, MODE_SWIRQ};
  logic [31:0] pins [4] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
  ccu_row_t rows [8] = '{'{ADDR_U1_LO, 32'hFFFF_FFA5, 32'h0000_00A5},
    '{ADDR_U1_HI, 32'h0000_015A, 32'h0000_005A}, '{ADDR_U1_CTL, 32'h0000_00F0, 32'h0000_00F0},
    '{ADDR_U2_CTL, 32'h0000_00F0, 32'h0000_0030}, '{ADDR_TSEL, 32'h0000_00FF, 32'h0000_0003},
    '{ADDR_MASK, 32'h0000_00FF, 32'h0000_0003}, '{ADDR_PINS, 32'h0000_00FF, 32'h0000_0003},
    '{8'h30, 32'h0000_00FF, 32'h0000_0000}};
  ccu_compare_unit u_ccu_compare_unit (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_one_count(t1), .timer_three_count(t3), .adc_enabled(adc_enabled),
    .timer_one_clear(t1c), .timer_three_clear(t3c), .adc_start(adc_start),
    .compare_pin_out(pin_out), .compare_pin_oe(pin_oe), .irq(irq));
  ccu_far_side #(.WRAP_MASK(16'h00FF)) u_ccu_far_side (.clock(clock), .rst(rst), .hold(hold),
    .adc_on(adc_on), .timer_one_clear(t1c), .timer_three_clear(t3c), .adc_start(adc_start),
    .timer_one_count(t1), .timer_three_count(t3), .adc_enabled(adc_enabled),
    .n_clr1(n_clr1), .n_clr3(n_clr3), .n_conv(n_conv));
  initial forever #20 clock = ~clock;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Requests are held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  // Clears both flags, lets the timers run and polls until the unit flags a match.
  task automatic match(input int idx);
    wr(ADDR_STATUS, 8'h03);
    c1 = n_clr1;
    c3 = n_clr3;
    cv = n_conv;
    hold <= 1'b0;
    for (int n = 0; n < 400 && rd[idx] !== 1'b1; n++) apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(32'(rd[idx]), 32'h0000_0001);
  endtask
  task automatic close_out;
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #4_000_000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk(rd, rows[i].r);
    end
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    hold <= 1'b1;
    wr(ADDR_PINS, 8'h03);
    wr(ADDR_U1_LO, 8'h40);
    @(negedge clock);
    chk(32'(pin_oe), 32'h0000_0003);
    for (int m = 0; m < 4; m++) begin
      hold <= 1'b1;
      wr(ADDR_U1_CTL, {4'h0, modes[m]});
      @(negedge clock);
      if (m == 0) chk(32'(pin_out[0]), 32'h0000_0001);
      match(0);
      @(negedge clock);
      chk(32'(pin_out[0]), pins[m]);
    end
    // Freeze the timer on the compare value: the flag must fire only once.
    wr(ADDR_STATUS, 8'h03);
    while (t1 !== 16'h003F) @(posedge clock);
    hold <= 1'b1;
    repeat (20) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(ADDR_MASK, 8'h01);
    @(negedge clock);
    chk(32'(irq), 32'h0000_0001);
    wr(ADDR_STATUS, 8'h01);
    repeat (20) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wr(ADDR_U1_CTL, {4'h0, MODE_SPECIAL});
    match(0);
    chk(32'(n_clr1 - c1), 32'h0000_0001);
    chk(32'(n_clr3 - c3 + n_conv - cv), 32'h0000_0000);
    wr(ADDR_U1_CTL, 8'h00);
    hold <= 1'b1;
    wr(ADDR_TSEL, 8'h01);
    wr(ADDR_U2_LO, 8'h30);
    wr(ADDR_U2_CTL, {4'h0, MODE_SPECIAL});
    adc_on <= 1'b1;
    match(1);
    chk(32'(n_clr3 - c3), 32'h0000_0001);
    chk(32'(n_clr1 - c1), 32'h0000_0000);
    chk(32'(n_conv - cv), 32'h0000_0001);
    adc_on <= 1'b0;
    match(1);
    chk(32'(n_conv - cv), 32'h0000_0000);
    wr(ADDR_U2_CTL, {4'h0, MODE_SET_HI});
    match(1);
    @(negedge clock);
    chk(32'(pin_out[1]), 32'h0000_0001);
    wr(ADDR_U2_CTL, 8'h00);
    @(negedge clock);
    chk(32'(pin_out[1]), 32'h0000_0000);
    close_out;
  end
endmodule
